// *** verilog/strap_latch_defines.svh ***
// Purpose: Constants for the strap latch and memory pin multiplexer.
// Assumes: Included by bare name from design files.
// Notes:   Bit positions refer to the latched strap word.
`ifndef STRAP_LATCH_DEFINES_SVH
`define STRAP_LATCH_DEFINES_SVH
`define STRAP_W          7
`define STRAP_TYPE_BIT   0
`define STRAP_SIZE0_BIT  1
`define STRAP_SIZE1_BIT  2
`define STRAP_IND_BIT    3
`define STRAP_PHY_BIT    4
`define STRAP_MDIX1_BIT  5
`define STRAP_MDIX2_BIT  6
`define STRAP_RESET_VAL  7'h00
`define PHY_ADDR_W       5
`define PHY_VIRT_BASE    5'h00
`define PHY_PORT1_BASE   5'h01
`define PHY_PORT2_BASE   5'h02
`define IND_PIN_COUNT    8
`endif

// *** verilog/strap_latch_pkg.sv ***
// Purpose: Types for the strap latch.
// Assumes: Nothing.
// Notes:   Memory type encoding follows the type strap level.
package strap_latch_pkg;
   typedef enum logic {MEM_WIRE3 = 1'b0, MEM_I2C = 1'b1} mem_type_t;
   typedef enum logic [1:0] {ST_POR, ST_HOLD_RESET, ST_RUN} latch_state_t;
endpackage

// *** verilog/strap_sync.sv ***
// Purpose: Two-flop synchroniser for a group of level inputs.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(parameter int W = 1)
(
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   // Shift each bit through two stages.
   always_comb
   begin
      next_state.meta   = async_in;
      next_state.stable = state.meta;
      if (rst)
      begin
         next_state = '0;
      end
   end

   // Register the copy.
   always_ff @(posedge sys_clk)
   begin
      state <= next_state;
   end

   assign sync_out = state.stable;
endmodule
`default_nettype wire

// *** verilog/strap_latch_eeprom_pinmux.sv ***
// Purpose: Latches configuration straps and steers the memory pins.
// Assumes: sys_clk at 200 MHz; straps held stable around reset release.
// Notes:   Strap pins shared with memory outputs are sampled while the
//          block holds the output enables off.
// Operation
// - Three-wire mode drives the serial clock onto its dedicated pin.
// - I2C mode uses the clock pin open-drain, never driving it high.
// - Chip select driven in three-wire mode, held low in I2C mode.
// - Size bit one comes from strap one, ignored in I2C mode.
// - Size bit zero comes from strap zero, shared with chip select.
// - Straps sampled at power-on and external reset release, then held.
// - Memory loader may later replace chosen latched strap values.
`timescale 1ns/1ps
`default_nettype none
`include "strap_latch_defines.svh"
module strap_latch_eeprom_pinmux
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    external_reset_n,
   input  wire logic                    mem_type_strap,
   input  wire logic                    size1_strap,
   input  wire logic                    wire3_chip_select_in,
   input  wire logic                    indicator_enable_strap,
   input  wire logic                    phy_base_select_strap,
   input  wire logic                    port1_crossover_strap,
   input  wire logic                    port2_crossover_strap,
   input  wire logic                    loader_override,
   input  wire logic [`STRAP_W-1:0]     loader_mask,
   input  wire logic [`STRAP_W-1:0]     loader_value,
   input  wire logic                    ctl_serial_clock,
   input  wire logic                    ctl_chip_select,
   input  wire logic                    ctl_i2c_clock_low,
   output logic                         wire3_serial_clock_out,
   output logic                         wire3_chip_select_out,
   output logic                         wire3_chip_select_oe_n,
   input  wire logic                    i2c_cfg_mem_clock_in,
   output logic                         i2c_cfg_mem_clock_out,
   output logic                         i2c_cfg_mem_clock_oe_n,
   output logic                         i2c_clock_sensed,
   output logic                         straps_valid,
   output logic                         mem_is_i2c,
   output logic [1:0]                   mem_size_sel,
   output logic [`IND_PIN_COUNT-1:0]    indicator_config_reg,
   output logic [`PHY_ADDR_W-1:0]       phy_addr_virtual,
   output logic [`PHY_ADDR_W-1:0]       phy_addr_port1,
   output logic [`PHY_ADDR_W-1:0]       phy_addr_port2,
   output logic                         port1_crossover_en,
   output logic                         port2_crossover_en
);
   localparam int NSYNC = `STRAP_W + 2;

   typedef struct packed
   {
      strap_latch_pkg::latch_state_t fsm;
      logic [`STRAP_W-1:0]           straps;
      logic                          valid;
      logic                          out_clk;
      logic                          out_cs;
      logic                          i2c_low;
   } top_state_t;

   top_state_t       state;
   top_state_t       next_state;
   logic [NSYNC-1:0] raw_pins;
   logic [NSYNC-1:0] sync_pins;
   logic [`STRAP_W-1:0] sampled;
   logic             ext_rst_n_s;
   logic             scl_s;
   logic             is_i2c;

   // Adds the PHY strap bit to a fixed base.
   function automatic logic [`PHY_ADDR_W-1:0] phy_addr
   (
      input logic [`PHY_ADDR_W-1:0] base,
      input logic                   sel
   );
      phy_addr = base + {{(`PHY_ADDR_W-1){1'b0}}, sel};
   endfunction

   // All pins arrive from the board, so they pass two flops first.
   assign raw_pins = {i2c_cfg_mem_clock_in, external_reset_n,
                      port2_crossover_strap, port1_crossover_strap,
                      phy_base_select_strap, indicator_enable_strap,
                      size1_strap, wire3_chip_select_in, mem_type_strap};

   strap_sync #(.W(NSYNC)) u_sync
   (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in (raw_pins),
      .sync_out (sync_pins)
   );

   assign sampled     = sync_pins[`STRAP_W-1:0];
   assign ext_rst_n_s = sync_pins[`STRAP_W];
   assign scl_s       = sync_pins[`STRAP_W+1];
   assign is_i2c      = state.straps[`STRAP_TYPE_BIT];

   // Sample after power-on, and again when external reset releases;
   // the synchroniser needs two edges, so sampling waits one extra.
   always_comb
   begin
      next_state         = state;
      next_state.out_clk = 1'b0;
      next_state.out_cs  = 1'b0;
      next_state.i2c_low = 1'b0;
      case (state.fsm)
         strap_latch_pkg::ST_POR:
         begin
            if (!ext_rst_n_s)
            begin
               next_state.fsm = strap_latch_pkg::ST_HOLD_RESET;
            end
            else
            begin
               next_state.straps = sampled;
               next_state.valid  = 1'b1;
               next_state.fsm    = strap_latch_pkg::ST_RUN;
            end
         end
         strap_latch_pkg::ST_HOLD_RESET:
         begin
            next_state.valid = 1'b0;
            if (ext_rst_n_s)
            begin
               next_state.straps = sampled;
               next_state.valid  = 1'b1;
               next_state.fsm    = strap_latch_pkg::ST_RUN;
            end
         end
         strap_latch_pkg::ST_RUN:
         begin
            if (!ext_rst_n_s)
            begin
               next_state.valid = 1'b0;
               next_state.fsm   = strap_latch_pkg::ST_HOLD_RESET;
            end
            else
            begin
               if (loader_override)
               begin
                  next_state.straps = (state.straps & ~loader_mask)
                                    | (loader_value & loader_mask);
               end
               // Steer by the mode that holds next cycle, so an override
               // that changes the memory type never leaks a stale strobe.
               if (next_state.straps[`STRAP_TYPE_BIT])
               begin
                  next_state.i2c_low = ctl_i2c_clock_low;
               end
               else
               begin
                  next_state.out_clk = ctl_serial_clock;
                  next_state.out_cs  = ctl_chip_select;
               end
            end
         end
         default:
         begin
            next_state.fsm = strap_latch_pkg::ST_POR;
         end
      endcase
      if (rst)
      begin
         next_state        = '0;
         next_state.fsm    = strap_latch_pkg::ST_POR;
         next_state.straps = `STRAP_RESET_VAL;
      end
   end

   // Register the copy.
   always_ff @(posedge sys_clk)
   begin
      state <= next_state;
   end

   // Chip select pin floats until straps are valid so its strap reads.
   assign wire3_serial_clock_out = state.out_clk;
   assign wire3_chip_select_out  = state.out_cs;
   assign wire3_chip_select_oe_n = ~state.valid;
   // Open drain: output level is always low, only the enable moves.
   assign i2c_cfg_mem_clock_out  = 1'b0;
   assign i2c_cfg_mem_clock_oe_n = ~state.i2c_low;
   assign i2c_clock_sensed       = scl_s;

   assign straps_valid = state.valid;
   assign mem_is_i2c   = is_i2c;
   assign mem_size_sel = {state.straps[`STRAP_SIZE1_BIT] & ~is_i2c,
                          state.straps[`STRAP_SIZE0_BIT]};
   assign indicator_config_reg =
      {`IND_PIN_COUNT{state.straps[`STRAP_IND_BIT]}};
   assign phy_addr_virtual = phy_addr(`PHY_VIRT_BASE,
                                      state.straps[`STRAP_PHY_BIT]);
   assign phy_addr_port1   = phy_addr(`PHY_PORT1_BASE,
                                      state.straps[`STRAP_PHY_BIT]);
   assign phy_addr_port2   = phy_addr(`PHY_PORT2_BASE,
                                      state.straps[`STRAP_PHY_BIT]);
   assign port1_crossover_en = state.straps[`STRAP_MDIX1_BIT];
   assign port2_crossover_en = state.straps[`STRAP_MDIX2_BIT];

   // The clock pin is only ever pulled low, and only in I2C mode.
   chk_i2c_never_high: assert property (
      @(posedge sys_clk) disable iff (rst)
      !i2c_cfg_mem_clock_oe_n |-> is_i2c && !i2c_cfg_mem_clock_out)
      else $error("I2C clock pulled outside I2C mode or driven high.");
   chk_cs_low_i2c: assert property (
      @(posedge sys_clk) disable iff (rst)
      is_i2c |-> !wire3_chip_select_out)
      else $error("Chip select not low in I2C mode.");
   chk_clk_follows_ctl: assert property (
      @(posedge sys_clk) disable iff (rst)
      (state.fsm == strap_latch_pkg::ST_RUN && ext_rst_n_s && !is_i2c
       && !loader_override)
      |=> wire3_serial_clock_out == $past(ctl_serial_clock))
      else $error("Serial clock not forwarded.");
   chk_size1_ignored: assert property (
      @(posedge sys_clk) disable iff (rst)
      is_i2c |-> !mem_size_sel[1])
      else $error("Size bit one used in I2C mode.");
   // Size bit zero comes from the shared pin, sampled while released.
   chk_size0_source: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(straps_valid)
      |-> mem_size_sel[0] == $past(sampled[`STRAP_SIZE0_BIT])
          && $past(wire3_chip_select_oe_n, 2))
      else $error("Size bit zero wrong.");
   chk_latch_release: assert property (
      @(posedge sys_clk) disable iff (rst)
      (state.fsm == strap_latch_pkg::ST_HOLD_RESET && ext_rst_n_s)
      |=> straps_valid && state.straps == $past(sampled))
      else $error("Straps not sampled at release.");
   chk_straps_hold: assert property (
      @(posedge sys_clk) disable iff (rst)
      ($past(state.fsm) == strap_latch_pkg::ST_RUN
       && state.fsm == strap_latch_pkg::ST_RUN && !$past(loader_override))
      |-> $stable(state.straps))
      else $error("Straps changed without event.");
   chk_loader_write: assert property (
      @(posedge sys_clk) disable iff (rst)
      (state.fsm == strap_latch_pkg::ST_RUN && ext_rst_n_s && loader_override)
      |=> ((state.straps & $past(loader_mask))
           == ($past(loader_value) & $past(loader_mask))))
      else $error("Loader override lost.");
   // The indicator default follows the strap pin as it was sampled.
   chk_ind_default: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(straps_valid)
      |-> indicator_config_reg
          == {`IND_PIN_COUNT{$past(sampled[`STRAP_IND_BIT])}})
      else $error("Indicator default wrong.");
   chk_phy_spacing: assert property (
      @(posedge sys_clk) disable iff (rst)
      phy_addr_port2 == phy_addr_virtual + 5'h02
      && phy_addr_port1 == phy_addr_virtual + 5'h01
      && phy_addr_virtual == {4'h0, state.straps[`STRAP_PHY_BIT]})
      else $error("PHY addresses wrong.");
   chk_mdix_source: assert property (
      @(posedge sys_clk) disable iff (rst)
      {port2_crossover_en, port1_crossover_en}
      == state.straps[`STRAP_MDIX2_BIT:`STRAP_MDIX1_BIT])
      else $error("Crossover enable wrong.");
endmodule
`default_nettype wire

// *** dv/strap_board_model.sv ***
// Purpose: Board strap resistors and configuration memory pins.
// Assumes: Pull-up on the I2C clock line.
// Notes:   Stretch holds the clock low as a slow memory would.
`timescale 1ns/1ps
`default_nettype none
module strap_board_model
(
   input  wire logic       size0,
   input  wire logic       stretch,
   input  wire logic       cs_out,
   input  wire logic       cs_oe_n,
   input  wire logic       scl_out,
   input  wire logic       scl_oe_n,
   output logic            cs_pin,
   output logic            scl_pin
);
   // A released pin shows its resistor level, never the last driven value.
   assign cs_pin  = cs_oe_n ? size0 : cs_out;
   assign scl_pin = (!scl_oe_n && !scl_out) || stretch ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// *** dv/strap_latch_eeprom_pinmux_test.sv ***
// Purpose: Self-checking bench for the strap latch and pin steering.
// Assumes: Straps held steady while the external reset is low.
// Notes:   Random strap words with all-zero and all-one corners.
`timescale 1ns/1ps
`default_nettype none
`include "strap_latch_defines.svh"
module strap_latch_eeprom_pinmux_test;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic       ern = 1'b0;
   logic       ovr = 1'b0;
   logic       c_sck = 1'b0;
   logic       c_cs = 1'b0;
   logic       c_low = 1'b0;
   logic       stretch = 1'b0;
   logic [6:0] strap = 7'h00;
   logic [6:0] mask = 7'h00;
   logic [6:0] val = 7'h00;
   logic [6:0] w;
   logic       sck_o, cs_o, cs_oen, scl_o, scl_oen, scl_s, valid, is_i2c;
   logic       x1, x2, cs_pin, scl_pin;
   logic [1:0] size_sel;
   logic [7:0] ind;
   logic [4:0] pv, p1, p2;
   integer     seed = 61771;
   integer     n_fail = 0;
   integer     checked = 0;
   integer     cyc = 0;
   integer     i, k;

   strap_latch_eeprom_pinmux i_strap_latch_eeprom_pinmux
   (
      .sys_clk(sys_clk), .rst(rst), .external_reset_n(ern),
      .mem_type_strap(strap[0]), .size1_strap(strap[2]),
      .wire3_chip_select_in(cs_pin), .indicator_enable_strap(strap[3]),
      .phy_base_select_strap(strap[4]), .port1_crossover_strap(strap[5]),
      .port2_crossover_strap(strap[6]), .loader_override(ovr),
      .loader_mask(mask), .loader_value(val), .ctl_serial_clock(c_sck),
      .ctl_chip_select(c_cs), .ctl_i2c_clock_low(c_low),
      .wire3_serial_clock_out(sck_o), .wire3_chip_select_out(cs_o),
      .wire3_chip_select_oe_n(cs_oen), .i2c_cfg_mem_clock_in(scl_pin),
      .i2c_cfg_mem_clock_out(scl_o), .i2c_cfg_mem_clock_oe_n(scl_oen),
      .i2c_clock_sensed(scl_s), .straps_valid(valid), .mem_is_i2c(is_i2c),
      .mem_size_sel(size_sel), .indicator_config_reg(ind),
      .phy_addr_virtual(pv), .phy_addr_port1(p1), .phy_addr_port2(p2),
      .port1_crossover_en(x1), .port2_crossover_en(x2)
   );

   strap_board_model i_strap_board_model
   (
      .size0(strap[1]), .stretch(stretch), .cs_out(cs_o),
      .cs_oe_n(cs_oen), .scl_out(scl_o), .scl_oe_n(scl_oen),
      .cs_pin(cs_pin), .scl_pin(scl_pin)
   );

   // Free-running system clock.
   always #2.5 sys_clk = ~sys_clk;

   // Compare and count; unknowns never pass.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Expected PHY address from its base and the strap.
   function automatic logic [7:0] phy(input logic [4:0] b, input logic s);
      return 8'(b + 5'(s));
   endfunction

   // Check every decode against the expected latched word.
   task automatic check_word(input logic [6:0] e);
      @(posedge sys_clk);
      #1;
      check(8'(valid), 8'h01);
      check(8'(is_i2c), 8'(e[0]));
      check(8'(size_sel[0]), 8'(e[1]));
      check(8'(size_sel[1]), 8'(e[2] && !e[0]));
      check(ind, {8{e[3]}});
      check(8'(pv), phy(`PHY_VIRT_BASE, e[4]));
      check(8'(p1), phy(`PHY_PORT1_BASE, e[4]));
      check(8'(p2), phy(`PHY_PORT2_BASE, e[4]));
      check(8'({x2, x1}), 8'(e[6:5]));
   endtask

   // Pulse the external reset, then show later strap changes are ignored.
   task automatic latch_straps(input logic [6:0] s);
      @(posedge sys_clk);
      strap <= s;
      ern <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      check(8'({valid, cs_oen}), 8'h01);
      @(posedge sys_clk);
      ern <= 1'b1;
      for (k = 0; k < 10 && valid !== 1'b1; k++)
         @(posedge sys_clk);
      check_word(s);
      @(posedge sys_clk);
      strap <= ~s;
      repeat (3) @(posedge sys_clk);
      check_word(s);
   endtask

   // One serial frame: controller clock at 160 ns, random controls.
   task automatic frame(input logic [6:0] e);
      logic [2:0] r;
      for (int h = 0; h < 4; h++)
      begin
         r = 3'($random(seed));
         @(posedge sys_clk);
         c_sck <= h[0];
         c_cs <= r[0];
         c_low <= r[1];
         stretch <= r[2];
         repeat (4) @(posedge sys_clk);
         #1;
         check(8'(sck_o), 8'(!e[0] && h[0]));
         check(8'({cs_oen, cs_o}), 8'(!e[0] && r[0]));
         check(8'({scl_o, scl_oen}), 8'(!(e[0] && r[1])));
         check(8'(scl_s), 8'(!(r[2] || (e[0] && r[1]))));
         repeat (11) @(posedge sys_clk);
      end
      c_sck <= 1'b0;
      stretch <= 1'b0;
   endtask

   // Main sequence: latch, run a frame, then a masked loader write.
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      for (i = 0; i < 24; i++)
      begin
         w = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($random(seed));
         latch_straps(w);
         frame(w);
         @(posedge sys_clk);
         ovr <= 1'b1;
         mask <= 7'($random(seed));
         val <= 7'($random(seed));
         @(posedge sys_clk);
         ovr <= 1'b0;
         check_word((w & ~mask) | (val & mask));
      end
      // Power-on again with the external reset high: the straps must be
      // taken once the synchroniser has refilled, not from its reset zeros.
      w = 7'($random(seed));
      @(posedge sys_clk);
      strap <= w;
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      check(8'({valid, cs_oen}), 8'h01);
      @(posedge sys_clk);
      rst <= 1'b0;
      for (k = 0; k < 10 && valid !== 1'b1; k++)
         @(posedge sys_clk);
      check_word(w);
      wrap_up;
   end

   // Cut a hang short; the whole run needs about 2000 cycles.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         n_fail++;
         wrap_up;
      end
   end

   // Print the counts and the verdict, then stop.
   task automatic wrap_up;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
endmodule
`default_nettype wire
